// file: include/engine_setup_regs.vh
// register offsets, field positions, reset values and timing counts for the engine setup block
// How it works
// R1: trim-window enable bit set makes the trim page readable in program space.
// R2: trim page base is 1024 times the six-bit engine code location.
// R3: firmware clears the trim-window enable after reading trim values.
// R4: temperature bits 10..8 at offset 0x90, bits 7..0 at 0x91.
// R5: hot reference deviation high byte at 0x92, low byte at 0x93.
// R6: room reference deviation byte readable at offset 0x94.
// R7: display high adjust at 0x95, display zero adjust at 0x96.
// R8: short trim values sit right-aligned from bit 0, upper bits zero.
// R9: firmware reads trim bytes only by code fetches, one byte each.
// R10: firmware sign-extends trim values when widening them.
// R11: engine data words are four bytes, two's complement.
// R12: engine word n maps big-endian at byte 4n through 4n+3.
// R13: firmware loads calibration into engine data before enabling the engine.
// R14: 13-bit sample count split over two registers sets accumulation length.
// R15: firmware completes the setup sequence before setting engine enable.
// R16: frame is fifteen slow-clock periods, one settling, fourteen converting.
// R17: default filter length 01 and seven conversions per frame.
// R18: three-bit equation field at bits 7..5 selects the meter equation.
// R19: code 5 sums three phase products.
// R20: code 2 sums phase A and phase B products.
// R21: code 3 is VA*(IA-IB)/2 plus VC*IC.
// R22: code 4 is VA*(IA-IB)/2 plus VB*(IC-IB)/2.
// R23: window closed returns flash; trim page is never writable.
`ifndef ENGINE_SETUP_REGS_VH
`define ENGINE_SETUP_REGS_VH

`define OFS_FRAME_CONV      16'h2100
`define OFS_EQU_ENABLE      16'h2106
`define OFS_SAMPLE_HIGH     16'h2107
`define OFS_SAMPLE_LOW      16'h2108
`define OFS_CODE_LOCATION   16'h2109
`define OFS_DIFF_FILTER     16'h210C
`define OFS_TRIM_WINDOW     16'h270B

`define TRIM_TEMP_HIGH      10'h090
`define TRIM_TEMP_LOW       10'h091
`define TRIM_REF_HOT_HIGH   10'h092
`define TRIM_REF_HOT_LOW    10'h093
`define TRIM_REF_ROOM       10'h094
`define TRIM_DISP_HIGH      10'h095
`define TRIM_DISP_ZERO      10'h096

`define CONV_FIELD_MSB      7
`define CONV_FIELD_LSB      4
`define EQU_FIELD_MSB       7
`define EQU_FIELD_LSB       5
`define ENGINE_ENABLE_BIT   0
`define FILTER_FIELD_MSB    1
`define FILTER_FIELD_LSB    0
`define DIFF_ENABLE_BIT     4
`define WINDOW_ENABLE_BIT   0

`define RST_CONV_PER_FRAME  4'h7
`define RST_FILTER_LENGTH   2'h1
`define RST_EQUATION        3'h5
`define RST_SAMPLE_COUNT    13'h0000
`define RST_CODE_LOCATION   6'h00

`define EQU_TWO_ELEMENT     3'h2
`define EQU_FOUR_W_DELTA    3'h3
`define EQU_FOUR_W_WYE      3'h4
`define EQU_THREE_ELEMENT   3'h5

`define FRAME_SLOW_TICKS    4'hF
`define FRAME_CONV_TICKS    5'h0E
`define ENGINE_RAM_WORDS    256
`define ENGINE_RAM_LIMIT    16'h0400

`endif

// file: rtl/engine_data_ram.v
// engine data memory with big-endian byte view for the processor and word view for the engine
`timescale 1ns/1ps
`include "engine_setup_regs.vh"
module engine_data_ram (
  input  wire        clk_sys_i,
  input  wire        byte_wr_i,
  input  wire [9:0]  byte_addr_i,
  input  wire [7:0]  byte_wdata_i,
  output reg  [7:0]  byte_rdata_o,
  input  wire [7:0]  word_addr_i,
  output reg  [31:0] word_rdata_o
);
  // R11 four-byte words
  reg [31:0] mem [0:`ENGINE_RAM_WORDS-1];
  wire [7:0] word_sel;
  wire [1:0] lane;
  assign word_sel = byte_addr_i[9:2];
  assign lane     = byte_addr_i[1:0];

  // R12 big-endian lanes
  always @(posedge clk_sys_i)
  begin
    if (byte_wr_i)
    begin
      case (lane)
        2'h0: mem[word_sel][31:24] <= byte_wdata_i;
        2'h1: mem[word_sel][23:16] <= byte_wdata_i;
        2'h2: mem[word_sel][15:8]  <= byte_wdata_i;
        default: mem[word_sel][7:0] <= byte_wdata_i;
      endcase
    end
    case (lane)
      2'h0: byte_rdata_o <= mem[word_sel][31:24];
      2'h1: byte_rdata_o <= mem[word_sel][23:16];
      2'h2: byte_rdata_o <= mem[word_sel][15:8];
      default: byte_rdata_o <= mem[word_sel][7:0];
    endcase
    word_rdata_o <= mem[word_addr_i];
  end
endmodule

// file: rtl/engine_setup.v
// engine setup registers, trim window on program fetches, frame timing and energy accumulation
`timescale 1ns/1ps
`include "engine_setup_regs.vh"
module engine_setup (
  input  wire               clk_sys_i,
  input  wire               reset_n_i,
  // processor data-space port
  input  wire [15:0]        data_addr_i,
  input  wire               data_wr_i,
  input  wire               data_rd_i,
  input  wire [7:0]         data_wdata_i,
  output reg  [7:0]         data_rdata_o,
  // processor program-fetch port
  input  wire [15:0]        code_addr_i,
  input  wire               code_rd_i,
  input  wire [7:0]         flash_data_i,
  output reg  [7:0]         code_rdata_o,
  // factory trim fuses
  input  wire [10:0]        fuse_temp_hot_i,
  input  wire [15:0]        fuse_ref_hot_i,
  input  wire [7:0]         fuse_ref_room_i,
  input  wire [7:0]         fuse_display_high_i,
  input  wire [7:0]         fuse_display_zero_i,
  // slow clock tick and samples
  input  wire               slow_tick_i,
  input  wire               sample_valid_i,
  input  wire signed [15:0] va_i,
  input  wire signed [15:0] vb_i,
  input  wire signed [15:0] vc_i,
  input  wire signed [15:0] ia_i,
  input  wire signed [15:0] ib_i,
  input  wire signed [15:0] ic_i,
  // engine side
  input  wire [7:0]         engine_word_addr_i,
  output wire [31:0]        engine_word_o,
  output reg                engine_enable_o,
  output reg  [2:0]         equation_o,
  output reg  [3:0]         conv_per_frame_o,
  output reg  [1:0]         filter_length_o,
  output reg                differential_enable_o,
  output reg                frame_start_o,
  output reg                settle_slot_o,
  output reg                frame_config_ok_o,
  output reg  signed [47:0] energy_o,
  output reg                accum_done_o
);
  reg  [3:0]  conv_per_frame_q;
  reg  [2:0]  equation_q;
  reg         engine_enable_q;
  reg  [12:0] sample_count_q;
  reg  [5:0]  code_location_q;
  reg  [1:0]  filter_length_q;
  reg         differential_enable_q;
  reg         trim_window_enable_q;
  reg  [3:0]  slow_count_q;
  reg  [12:0] sums_done_q;
  reg  signed [47:0] accum_q;
  reg  [7:0]  reg_rdata_d;
  reg  [7:0]  trim_byte_d;
  reg         trim_hit_d;
  reg         ram_read_q;
  reg  [7:0]  reg_rdata_q;

  wire        ram_sel;
  wire [7:0]  ram_byte;
  wire [9:0]  page_offset;
  wire        page_match;
  wire [5:0]  cycles_per_conv;
  wire [9:0]  conv_product;
  wire signed [33:0] power_total;
  wire        power_valid;

  // R12 engine data occupies the low data space
  assign ram_sel = (data_addr_i < `ENGINE_RAM_LIMIT);

  engine_data_ram u_ram (
    .clk_sys_i    (clk_sys_i),
    .byte_wr_i    (data_wr_i & ram_sel),
    .byte_addr_i  (data_addr_i[9:0]),
    .byte_wdata_i (data_wdata_i),
    .byte_rdata_o (ram_byte),
    .word_addr_i  (engine_word_addr_i),
    .word_rdata_o (engine_word_o)
  );

  power_equation u_eq (
    .clk_sys_i      (clk_sys_i),
    .reset_n_i      (reset_n_i),
    .sample_valid_i (sample_valid_i & engine_enable_q),
    .equation_i     (equation_q),
    .va_i           (va_i),
    .vb_i           (vb_i),
    .vc_i           (vc_i),
    .ia_i           (ia_i),
    .ib_i           (ib_i),
    .ic_i           (ic_i),
    .total_q        (power_total),
    .total_valid_q  (power_valid)
  );

  // register writes
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      conv_per_frame_q      <= `RST_CONV_PER_FRAME;
      equation_q            <= `RST_EQUATION;
      engine_enable_q       <= 1'b0;
      sample_count_q        <= `RST_SAMPLE_COUNT;
      code_location_q       <= `RST_CODE_LOCATION;
      filter_length_q       <= `RST_FILTER_LENGTH;
      differential_enable_q <= 1'b0;
      trim_window_enable_q  <= 1'b0;
    end
    else if (data_wr_i)
    begin
      case (data_addr_i)
        `OFS_FRAME_CONV:
          conv_per_frame_q <= data_wdata_i[`CONV_FIELD_MSB:`CONV_FIELD_LSB];
        `OFS_EQU_ENABLE:
        begin
          // R18 equation field
          equation_q      <= data_wdata_i[`EQU_FIELD_MSB:`EQU_FIELD_LSB];
          // R15 enable written last by firmware
          engine_enable_q <= data_wdata_i[`ENGINE_ENABLE_BIT];
        end
        // R14 split sample count
        `OFS_SAMPLE_HIGH:
          sample_count_q[12:8] <= data_wdata_i[4:0];
        `OFS_SAMPLE_LOW:
          sample_count_q[7:0] <= data_wdata_i;
        `OFS_CODE_LOCATION:
          code_location_q <= data_wdata_i[5:0];
        `OFS_DIFF_FILTER:
        begin
          filter_length_q       <= data_wdata_i[`FILTER_FIELD_MSB:`FILTER_FIELD_LSB];
          differential_enable_q <= data_wdata_i[`DIFF_ENABLE_BIT];
        end
        // R1 R3 window enable set and cleared by firmware
        `OFS_TRIM_WINDOW:
          trim_window_enable_q <= data_wdata_i[`WINDOW_ENABLE_BIT];
        default:
          trim_window_enable_q <= trim_window_enable_q;
      endcase
    end
  end

  // register read-back; reserved bits read zero, trim page has no data-space address
  always @*
  begin
    case (data_addr_i)
      `OFS_FRAME_CONV:    reg_rdata_d = {conv_per_frame_q, 4'h0};
      `OFS_EQU_ENABLE:    reg_rdata_d = {equation_q, 4'h0, engine_enable_q};
      `OFS_SAMPLE_HIGH:   reg_rdata_d = {3'h0, sample_count_q[12:8]};
      `OFS_SAMPLE_LOW:    reg_rdata_d = sample_count_q[7:0];
      `OFS_CODE_LOCATION: reg_rdata_d = {2'h0, code_location_q};
      `OFS_DIFF_FILTER:   reg_rdata_d = {3'h0, differential_enable_q, 2'h0, filter_length_q};
      `OFS_TRIM_WINDOW:   reg_rdata_d = {7'h00, trim_window_enable_q};
      default:            reg_rdata_d = 8'h00;
    endcase
  end

  // ram byte arrives one cycle after the address, so the mux is steered late
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ram_read_q  <= 1'b0;
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      ram_read_q  <= data_rd_i & ram_sel;
      reg_rdata_q <= data_rd_i ? reg_rdata_d : 8'h00;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      data_rdata_o <= 8'h00;
    else
      data_rdata_o <= ram_read_q ? ram_byte : reg_rdata_q;
  end

  // R2 page base on a 1KB boundary
  assign page_offset = code_addr_i[9:0];
  assign page_match  = (code_addr_i[15:10] == code_location_q);

  always @*
  begin
    trim_hit_d  = 1'b1;
    case (page_offset)
      // R4 R8 temperature split, upper bits zero
      `TRIM_TEMP_HIGH:    trim_byte_d = {5'h00, fuse_temp_hot_i[10:8]};
      `TRIM_TEMP_LOW:     trim_byte_d = fuse_temp_hot_i[7:0];
      // R5 hot reference bytes
      `TRIM_REF_HOT_HIGH: trim_byte_d = fuse_ref_hot_i[15:8];
      `TRIM_REF_HOT_LOW:  trim_byte_d = fuse_ref_hot_i[7:0];
      // R6 room reference byte
      `TRIM_REF_ROOM:     trim_byte_d = fuse_ref_room_i;
      // R7 display adjust bytes
      `TRIM_DISP_HIGH:    trim_byte_d = fuse_display_high_i;
      `TRIM_DISP_ZERO:    trim_byte_d = fuse_display_zero_i;
      default:
      begin
        trim_byte_d = 8'h00;
        trim_hit_d  = 1'b0;
      end
    endcase
  end

  // R1 R23 window open overlays the page; closed gives flash
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      code_rdata_o <= 8'h00;
    else if (code_rd_i)
    begin
      if (trim_window_enable_q && page_match)
        code_rdata_o <= trim_hit_d ? trim_byte_d : 8'h00;
      else
        code_rdata_o <= flash_data_i;
    end
  end

  // R16 frame timing on the slow clock tick
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      slow_count_q  <= 4'h0;
      frame_start_o <= 1'b0;
      settle_slot_o <= 1'b0;
    end
    else
    begin
      frame_start_o <= 1'b0;
      if (slow_tick_i && engine_enable_q)
      begin
        if (slow_count_q == `FRAME_SLOW_TICKS - 4'h1)
        begin
          slow_count_q  <= 4'h0;
          frame_start_o <= 1'b1;
          settle_slot_o <= 1'b1;
        end
        else
        begin
          slow_count_q  <= slow_count_q + 4'h1;
          settle_slot_o <= 1'b0;
        end
      end
      else if (!engine_enable_q)
      begin
        slow_count_q  <= 4'h0;
        settle_slot_o <= 1'b0;
      end
    end
  end

  // R16 R17 converting slots must total fourteen
  assign cycles_per_conv = {4'h0, filter_length_q} + 6'h01;
  assign conv_product    = cycles_per_conv * {6'h00, conv_per_frame_q};

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      engine_enable_o       <= 1'b0;
      equation_o            <= `RST_EQUATION;
      conv_per_frame_o      <= `RST_CONV_PER_FRAME;
      filter_length_o       <= `RST_FILTER_LENGTH;
      differential_enable_o <= 1'b0;
      frame_config_ok_o     <= 1'b1;
    end
    else
    begin
      engine_enable_o       <= engine_enable_q;
      equation_o            <= equation_q;
      conv_per_frame_o      <= conv_per_frame_q;
      filter_length_o       <= filter_length_q;
      differential_enable_o <= differential_enable_q;
      frame_config_ok_o     <= (conv_product == {5'h00, `FRAME_CONV_TICKS});
    end
  end

  // R14 accumulate over the programmed sample count; zero count closes an interval after 8192 samples
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      accum_q      <= 48'h000000000000;
      sums_done_q  <= 13'h0000;
      energy_o     <= 48'h000000000000;
      accum_done_o <= 1'b0;
    end
    else
    begin
      accum_done_o <= 1'b0;
      if (!engine_enable_q)
      begin
        accum_q     <= 48'h000000000000;
        sums_done_q <= 13'h0000;
      end
      else if (power_valid)
      begin
        if (sums_done_q + 13'h0001 == sample_count_q)
        begin
          energy_o     <= accum_q + {{14{power_total[33]}}, power_total};
          accum_done_o <= 1'b1;
          accum_q      <= 48'h000000000000;
          sums_done_q  <= 13'h0000;
        end
        else
        begin
          accum_q     <= accum_q + {{14{power_total[33]}}, power_total};
          sums_done_q <= sums_done_q + 13'h0001;
        end
      end
    end
  end
endmodule

// file: rtl/power_equation.v
// meter equation: combines phase voltage and current samples into total power
`timescale 1ns/1ps
`include "engine_setup_regs.vh"
module power_equation (
  input  wire               clk_sys_i,
  input  wire               reset_n_i,
  input  wire               sample_valid_i,
  input  wire [2:0]         equation_i,
  input  wire signed [15:0] va_i,
  input  wire signed [15:0] vb_i,
  input  wire signed [15:0] vc_i,
  input  wire signed [15:0] ia_i,
  input  wire signed [15:0] ib_i,
  input  wire signed [15:0] ic_i,
  output reg  signed [33:0] total_q,
  output reg                total_valid_q
);
  wire signed [16:0] ia_minus_ib;
  wire signed [16:0] ic_minus_ib;
  wire signed [15:0] half_ab;
  wire signed [15:0] half_cb;
  wire signed [31:0] p_aa;
  wire signed [31:0] p_bb;
  wire signed [31:0] p_cc;
  wire signed [31:0] p_a_half;
  wire signed [31:0] p_b_half;
  reg  signed [33:0] total_d;

  assign ia_minus_ib = {ia_i[15], ia_i} - {ib_i[15], ib_i};
  assign ic_minus_ib = {ic_i[15], ic_i} - {ib_i[15], ib_i};
  assign half_ab     = ia_minus_ib[16:1];
  assign half_cb     = ic_minus_ib[16:1];
  assign p_aa        = va_i * ia_i;
  assign p_bb        = vb_i * ib_i;
  assign p_cc        = vc_i * ic_i;
  assign p_a_half    = va_i * half_ab;
  assign p_b_half    = vb_i * half_cb;

  // R18 equation select
  always @*
  begin
    case (equation_i)
      // R20 two-element delta
      `EQU_TWO_ELEMENT:   total_d = {{2{p_aa[31]}}, p_aa} + {{2{p_bb[31]}}, p_bb};
      // R21 four-wire delta
      `EQU_FOUR_W_DELTA:  total_d = {{2{p_a_half[31]}}, p_a_half} + {{2{p_cc[31]}}, p_cc};
      // R22 four-wire wye
      `EQU_FOUR_W_WYE:    total_d = {{2{p_a_half[31]}}, p_a_half} + {{2{p_b_half[31]}}, p_b_half};
      // R19 three elements
      `EQU_THREE_ELEMENT: total_d = {{2{p_aa[31]}}, p_aa} + {{2{p_bb[31]}}, p_bb} + {{2{p_cc[31]}}, p_cc};
      // unsupported codes contribute nothing rather than a stale sum
      default:            total_d = 34'h000000000;
    endcase
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      total_q       <= 34'h000000000;
      total_valid_q <= 1'b0;
    end
    else
    begin
      total_valid_q <= sample_valid_i;
      if (sample_valid_i)
        total_q <= total_d;
    end
  end
endmodule

// file: tb/compute_engine_setup_and_trim_window_bench.sv
// self-checking bench for the engine setup block
`timescale 1ns/1ps
module compute_engine_setup_and_trim_window_bench;
  logic               clk_sys_i = 1'b0;
  logic               reset_n_i = 1'b0;
  logic [15:0]        data_addr_i = 16'h0000;
  logic               data_wr_i = 1'b0;
  logic               data_rd_i = 1'b0;
  logic [7:0]         data_wdata_i = 8'h00;
  logic [15:0]        code_addr_i = 16'h0000;
  logic               code_rd_i = 1'b0;
  logic [10:0]        fuse_temp_hot_i = 11'h5A3;
  logic [15:0]        fuse_ref_hot_i = 16'hF1C2;
  logic [7:0]         fuse_ref_room_i = 8'h8E;
  logic [7:0]         fuse_display_high_i = 8'h7B;
  logic [7:0]         fuse_display_zero_i = 8'hE4;
  logic               slow_tick_i = 1'b0;
  logic               sample_valid_i = 1'b0;
  logic signed [15:0] va_i = 16'sh0064;
  logic signed [15:0] vb_i = 16'shFF38;
  logic signed [15:0] vc_i = 16'sh012C;
  logic signed [15:0] ia_i = 16'sh0028;
  logic signed [15:0] ib_i = 16'shFFF6;
  logic signed [15:0] ic_i = 16'sh0007;
  logic [7:0]         engine_word_addr_i = 8'h00;
  logic [1:0]         tick_div = 2'h0;
  logic [7:0]         data_rdata_o, code_rdata_o, flash_data_i;
  logic [31:0]        engine_word_o;
  logic [2:0]         equation_o;
  logic [3:0]         conv_per_frame_o;
  logic [1:0]         filter_length_o;
  logic               engine_enable_o, differential_enable_o, frame_start_o, settle_slot_o;
  logic               frame_config_ok_o, accum_done_o;
  logic signed [47:0] energy_o;
  int                 n_checks = 0;
  int                 bad_count = 0;
  logic [15:0]        ra [7] = '{16'h2100, 16'h2106, 16'h2107, 16'h2108, 16'h2109, 16'h210C, 16'h270B};
  logic [7:0]         rv [7] = '{8'h70, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0]         rm [7] = '{8'hF0, 8'hE1, 8'h1F, 8'hFF, 8'h3F, 8'h13, 8'h01};

  flash_model flash (.code_addr_i, .flash_data_o(flash_data_i));
  engine_setup dut (.*);

  always #12.5 clk_sys_i = ~clk_sys_i;

  // one slow tick per four cycles keeps frames short
  always @(posedge clk_sys_i)
  begin
    tick_div <= tick_div + 2'h1;
    slow_tick_i <= (tick_div == 2'h3);
  end

  function automatic logic [7:0] fl(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  function automatic logic signed [47:0] power(input logic [2:0] q);
    logic signed [16:0] dab;
    logic signed [16:0] dcb;
    dab = (17'(ia_i) - 17'(ib_i)) >>> 1;
    dcb = (17'(ic_i) - 17'(ib_i)) >>> 1;
    case (q)
      3'h2: return va_i * ia_i + vb_i * ib_i;
      3'h3: return va_i * dab + vc_i * ic_i;
      3'h4: return va_i * dab + vb_i * dcb;
      3'h5: return va_i * ia_i + vb_i * ib_i + vc_i * ic_i;
      default: return 48'sh0;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    data_addr_i <= a;
    data_wdata_i <= d;
    data_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    data_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    data_addr_i <= a;
    data_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    data_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk($sformatf("read %h", a), {40'h0, e}, {40'h0, data_rdata_o});
  endtask

  task automatic fetch(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    code_addr_i <= a;
    code_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    code_rd_i <= 1'b0;
    #1 chk($sformatf("fetch %h", a), {40'h0, e}, {40'h0, code_rdata_o});
  endtask

  task automatic ram_word(input logic [7:0] n, input logic [31:0] w);
    for (int b = 0; b < 4; b++)
      wr({6'h00, n, 2'(b)}, w[31 - 8 * b -: 8]);
    @(posedge clk_sys_i);
    engine_word_addr_i <= n;
    repeat (2) @(posedge clk_sys_i);
    #1 chk($sformatf("word %0d", n), {16'h0, w}, {16'h0, engine_word_o});
  endtask

  task automatic wait_sig(input bit frm, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1 cyc++;
      if (cyc > 200)
      begin
        bad_count++;
        $display("mismatch pulse expected 1 seen 0");
        test_done();
      end
    end
    while ((frm ? frame_start_o : accum_done_o) !== 1'b1);
  endtask

  task automatic accumulate(input int n, input logic signed [47:0] e);
    int c;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b0;
    end
    wait_sig(1'b0, c);
    chk("energy", e, energy_o);
  endtask

  initial
  begin
    int c;
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1 chk("reset fields", 11'h576, {equation_o, conv_per_frame_o, filter_length_o, frame_config_ok_o, engine_enable_o});
    foreach (ra[i])
    begin
      rd(ra[i], rv[i]);
      wr(ra[i], 8'hFF);
      rd(ra[i], rm[i]);
      wr(ra[i], rv[i]);
    end
    wr(16'h2101, 8'h55);
    rd(16'h2101, 8'h00);
    rd(16'h0400, 8'h00);
    fetch(16'h0090, fl(16'h0090));
    wr(16'h2109, 8'h03);
    wr(16'h270B, 8'h01);
    fetch(16'h0C90, {5'h00, fuse_temp_hot_i[10:8]});
    fetch(16'h0C91, fuse_temp_hot_i[7:0]);
    fetch(16'h0C92, fuse_ref_hot_i[15:8]);
    fetch(16'h0C93, fuse_ref_hot_i[7:0]);
    fetch(16'h0C94, fuse_ref_room_i);
    fetch(16'h0C95, fuse_display_high_i);
    fetch(16'h0C96, fuse_display_zero_i);
    fetch(16'h0C97, 8'h00);
    fetch(16'h0890, fl(16'h0890));
    wr(16'h2109, 8'h3F);
    fetch(16'hFC94, fuse_ref_room_i);
    wr(16'h270B, 8'h00);
    fetch(16'hFC94, fl(16'hFC94));
    ram_word(8'h05, 32'h81234567);
    ram_word(8'hFF, 32'hFFFFFFFF);
    rd(16'h0015, 8'h23);
    wr(16'h2107, 8'h00);
    wr(16'h2108, 8'h01);
    wr(16'h210C, 8'h11);
    for (int q = 1; q < 6; q++)
    begin
      wr(16'h2106, {3'(q), 4'h0, 1'b1});
      accumulate(1, power(3'(q)));
    end
    wait_sig(1'b1, c);
    wait_sig(1'b1, c);
    chk("frame cycles", 48'd60, 48'(c));
    chk("settle slot", 48'h1, {47'h0, settle_slot_o});
    wr(16'h2100, 8'hE0);
    wr(16'h210C, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("frame config", 8'hE1, {conv_per_frame_o, filter_length_o, differential_enable_o, frame_config_ok_o});
    wr(16'h2100, 8'h60);
    wr(16'h210C, 8'h11);
    repeat (3) @(posedge clk_sys_i);
    #1 chk("frame config", 8'h66, {conv_per_frame_o, filter_length_o, differential_enable_o, frame_config_ok_o});
    wr(16'h2106, 8'hA0);
    va_i <= 16'shFED4;
    vb_i <= 16'sh0032;
    vc_i <= 16'shFFF9;
    ia_i <= 16'sh0005;
    ib_i <= 16'sh8000;
    ic_i <= 16'sh7FFF;
    wr(16'h2107, 8'h01);
    wr(16'h2106, 8'hA1);
    accumulate(257, 257 * power(3'h5));
    test_done();
  end
endmodule

// file: tb/engine_setup_properties.sv
// port-level assertions for the engine setup block, bound to every instance
`timescale 1ns/1ps
module engine_setup_properties (
  input wire        clk_sys_i,
  input wire        reset_n_i,
  input wire [15:0] data_addr_i,
  input wire        data_wr_i,
  input wire        data_rd_i,
  input wire [7:0]  data_wdata_i,
  input wire [7:0]  data_rdata_o,
  input wire [15:0] code_addr_i,
  input wire        code_rd_i,
  input wire [7:0]  flash_data_i,
  input wire [7:0]  code_rdata_o,
  input wire [10:0] fuse_temp_hot_i,
  input wire [15:0] fuse_ref_hot_i,
  input wire [7:0]  fuse_ref_room_i,
  input wire [7:0]  fuse_display_high_i,
  input wire [7:0]  fuse_display_zero_i,
  input wire        slow_tick_i,
  input wire        engine_enable_o,
  input wire [2:0]  equation_o,
  input wire [3:0]  conv_per_frame_o,
  input wire [1:0]  filter_length_o,
  input wire        frame_start_o,
  input wire        frame_config_ok_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic       win_q;
  logic [5:0] loc_q;
  logic [3:0] tick_q;
  logic       run_q;
  logic [7:0] trim_exp;
  logic [5:0] prod;
  logic       mapped;
  assign prod = (6'(filter_length_o) + 6'h01) * 6'(conv_per_frame_o);
  assign mapped = data_addr_i < 16'h0400 ||
                  data_addr_i inside {16'h2100, 16'h2106, 16'h2107, 16'h2108, 16'h2109, 16'h210C, 16'h270B};
  always_comb
    case (code_addr_i[9:0])
      10'h090: trim_exp = {5'h00, fuse_temp_hot_i[10:8]};
      10'h091: trim_exp = fuse_temp_hot_i[7:0];
      10'h092: trim_exp = fuse_ref_hot_i[15:8];
      10'h093: trim_exp = fuse_ref_hot_i[7:0];
      10'h094: trim_exp = fuse_ref_room_i;
      10'h095: trim_exp = fuse_display_high_i;
      10'h096: trim_exp = fuse_display_zero_i;
      default: trim_exp = 8'h00;
    endcase
  // tick count trusted only after a frame seen while enabled
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      win_q <= 1'b0;
      loc_q <= 6'h00;
      tick_q <= 4'h0;
      run_q <= 1'b0;
    end
    else
    begin
      if (data_wr_i && data_addr_i == 16'h270B)
        win_q <= data_wdata_i[0];
      if (data_wr_i && data_addr_i == 16'h2109)
        loc_q <= data_wdata_i[5:0];
      if (frame_start_o)
        tick_q <= 4'h0;
      else if (slow_tick_i)
        tick_q <= tick_q + 4'h1;
      run_q <= engine_enable_o && (run_q || frame_start_o);
    end
  AST_UNMAPPED_READ: assert property (data_rd_i && !mapped |-> ##2 data_rdata_o == 8'h00)
    else $error("unmapped read returned data");
  AST_TRIM_PAGE: assert property (code_rd_i && win_q && code_addr_i[15:10] == loc_q |=>
    code_rdata_o == $past(trim_exp)) else $error("trim page byte wrong");
  AST_OTHER_PAGE: assert property (code_rd_i && win_q && code_addr_i[15:10] != loc_q |=>
    code_rdata_o == $past(flash_data_i)) else $error("fetch outside trim page not flash");
  AST_WINDOW_SHUT: assert property (code_rd_i && !win_q |=> code_rdata_o == $past(flash_data_i))
    else $error("closed window fetch not flash");
  AST_FETCH_HOLD: assert property (!code_rd_i |=> $stable(code_rdata_o))
    else $error("fetch result changed without fetch");
  AST_EQUATION_FIELD: assert property (data_wr_i && data_addr_i == 16'h2106 |-> ##2
    equation_o == $past(data_wdata_i[7:5], 2) && engine_enable_o == $past(data_wdata_i[0], 2))
    else $error("equation or enable output wrong");
  AST_FRAME_CONFIG: assert property ($stable(filter_length_o) && $stable(conv_per_frame_o) |->
    frame_config_ok_o == (prod == 6'h0E)) else $error("frame config flag wrong");
  AST_IDLE_NO_FRAME: assert property (!engine_enable_o && !$past(engine_enable_o) |-> !frame_start_o)
    else $error("frame start while engine off");
  AST_FRAME_TICKS: assert property (frame_start_o && run_q |-> tick_q == 4'hF)
    else $error("frame not fifteen ticks long");
endmodule

bind engine_setup engine_setup_properties chk (.clk_sys_i, .reset_n_i, .data_addr_i, .data_wr_i, .data_rd_i,
  .data_wdata_i, .data_rdata_o, .code_addr_i, .code_rd_i, .flash_data_i, .code_rdata_o, .fuse_temp_hot_i,
  .fuse_ref_hot_i, .fuse_ref_room_i, .fuse_display_high_i, .fuse_display_zero_i, .slow_tick_i,
  .engine_enable_o, .equation_o, .conv_per_frame_o, .filter_length_o, .frame_start_o, .frame_config_ok_o);

// file: tb/flash_model.sv
// program flash model answering every fetch address in the same cycle
`timescale 1ns/1ps
module flash_model (
  input  logic [15:0] code_addr_i,
  output logic [7:0]  flash_data_o
);
  // byte differs from address to address so a wrong source cannot match by chance
  assign flash_data_o = code_addr_i[7:0] ^ code_addr_i[15:8] ^ 8'h3C;
endmodule
